// ### hdl/evs_pkg.sv
/*
 * constants for the exception vectoring and stack-select unit:
 * status register layout, exception kinds, register offsets, bus port widths.
 * assumes a 32-bit address and data path and a byte-addressed memory.
 */
package evs_pkg;

	typedef enum logic [1:0]
	{
		EVS_KIND_INTERNAL = 2'h0,
		EVS_KIND_IRQ      = 2'h1,
		EVS_KIND_COPROC   = 2'h2,
		EVS_KIND_RESET    = 2'h3
	} evs_kind_t;

	// status register fields
	localparam int          SR_TRACE_ANY  = 15;
	localparam int          SR_TRACE_FLOW = 14;
	localparam int          SR_SUPER      = 13;
	localparam int          SR_MASTER     = 12;
	localparam int          SR_IPL_LO     = 8;
	localparam int          SR_IPL_HI     = 10;
	localparam logic [15:0] SR_RESET_VAL  = 16'h2700;
	localparam logic [2:0]  IPL_RESET     = 3'h7;

	// register offsets (byte addresses)
	localparam logic [7:0] REG_STATUS_REG  = 8'h00;
	localparam logic [7:0] REG_VECTOR_BASE = 8'h04;
	localparam logic [7:0] REG_TASK_SP     = 8'h08;
	localparam logic [7:0] REG_IRQ_SP      = 8'h0C;
	localparam logic [7:0] REG_SAVED_SR    = 8'h10;
	localparam logic [7:0] REG_PROG_CNT    = 8'h14;
	localparam logic [7:0] REG_UNIT_STATE  = 8'h18;

	// answer of the addressed port on a bus cycle
	localparam logic [1:0] PORT_32 = 2'h0;
	localparam logic [1:0] PORT_8  = 2'h1;
	localparam logic [1:0] PORT_16 = 2'h2;

	localparam logic [7:0]  RESET_VECTOR  = 8'h00;
	localparam logic [2:0]  FRAME_WORDS   = 3'h4;
	localparam logic [31:0] WORD_BYTES    = 32'h0000_0002;
	localparam logic [2:0]  LONG_BYTES    = 3'h4;
	localparam logic [3:0]  THROWAWAY_FMT = 4'h1;
	localparam logic [31:0] IACK_BASE     = 32'hFFFF_FFF0;

endpackage

// ### hdl/evs_top.sv
/*
 * exception vectoring and stack selection: status update, vector number
 * source, throwaway frame, vector fetch with dynamic bus sizing, restart.
 * assumes a memory port that answers each request with a one-cycle ack and
 * a port width, and a core that raises one exception request at a time.
 */
//
// Overview of operation
// RULE1: with master bit set, task exceptions use the task stack pointer.
// RULE2: an interrupt clears the master bit and uses the interrupt stack pointer.
// RULE3: vector offset is vector number times four, a shift by two.
// RULE4: vector address is offset plus vector table base.
// RULE5: load program counter from the vector, then restart fetch there.
// RULE6: same vector fetch and restart for every exception kind.
// RULE7: save status copy, set supervisor, clear trace bits, update mask if needed.
// RULE8: interrupts get vector by acknowledge read, coprocessor from response, else internal.
// RULE9: interrupt with master set pushes four-word throwaway frame on task stack.
// RULE10: reset clears master bit, stacks nothing, fetches reset vector.
// RULE11: vector read as one long word with normal sizing of port width.
`timescale 1ns/1ps
module evs_top
(
	input  wire logic        sys_clk_i,
	input  wire logic        rst_n_i,
	input  wire logic [7:0]  reg_addr_i,
	input  wire logic [31:0] reg_wdata_i,
	input  wire logic        reg_we_i,
	input  wire logic        reg_re_i,
	output logic      [31:0] reg_rdata_o,
	input  wire logic        exc_req_i,
	input  wire logic [1:0]  exc_kind_i,
	input  wire logic [7:0]  exc_vec_i,
	input  wire logic [7:0]  cop_vec_i,
	input  wire logic [2:0]  exc_level_i,
	output logic             mem_req_o,
	output logic             mem_we_o,
	output logic             mem_iack_o,
	output logic      [31:0] mem_addr_o,
	output logic      [15:0] mem_wdata_o,
	input  wire logic        mem_ack_i,
	input  wire logic [1:0]  mem_port_i,
	input  wire logic [31:0] mem_rdata_i,
	output logic             busy_o,
	output logic             task_stack_o,
	output logic             restart_o,
	output logic      [31:0] fetch_pc_o
);

	typedef enum logic [2:0]
	{
		ST_IDLE,
		ST_IACK,
		ST_FRAME,
		ST_VEC,
		ST_DONE
	} evs_state_t;
	evs_state_t  state_q;
	logic [15:0] sr_q;
	logic [15:0] saved_sr_q;
	logic [31:0] vbr_q;
	logic [31:0] task_sp_q;
	logic [31:0] irq_sp_q;
	logic [31:0] pc_q;
	logic [31:0] acc_q;
	logic [7:0]  vec_q;
	logic [2:0]  got_q;
	logic [2:0]  word_q;
	logic        task_sel_q;
	logic        req_q;
	logic        restart_q;
	logic [31:0] rdata_q;
	logic        busy_q;
	wire         idle      = (state_q == ST_IDLE);
	wire         take_exc  = idle && exc_req_i;
	wire         acked     = req_q && mem_ack_i;
	wire         sw_write  = reg_we_i && idle;
	wire         kind_rst  = (exc_kind_i == evs_pkg::EVS_KIND_RESET);
	wire         kind_irq  = (exc_kind_i == evs_pkg::EVS_KIND_IRQ);
	wire         kind_cop  = (exc_kind_i == evs_pkg::EVS_KIND_COPROC);
	wire         master_on = sr_q[evs_pkg::SR_MASTER];
	wire [7:0]   int_vec   = kind_rst ? evs_pkg::RESET_VECTOR :
	                         (kind_cop ? cop_vec_i : exc_vec_i); // RULE8
	wire [31:0]  vec_off   = {22'h000000, vec_q, 2'h0}; // RULE3
	wire [31:0]  vec_addr  = vbr_q + vec_off + {29'h00000000, got_q}; // RULE4
	wire [31:0]  push_addr = task_sp_q - evs_pkg::WORD_BYTES;
	wire [31:0]  iack_addr = evs_pkg::IACK_BASE | {28'h0000000, sr_q[10:8], 1'b1};
	wire         need_bus  = (state_q == ST_IACK) || (state_q == ST_FRAME) ||
	                         (state_q == ST_VEC);
	wire         req_d     = need_bus && !acked;
	wire [2:0]   port_n    = (mem_port_i == evs_pkg::PORT_32) ? 3'h4 :
	                         ((mem_port_i == evs_pkg::PORT_16) ? 3'h2 : 3'h1);
	wire [31:0]  acc_d     = (mem_port_i == evs_pkg::PORT_32) ? mem_rdata_i :
	                         ((mem_port_i == evs_pkg::PORT_16) ?
	                          {acc_q[15:0], mem_rdata_i[31:16]} :
	                          {acc_q[23:0], mem_rdata_i[31:24]}); // RULE11
	wire [2:0]   got_d     = got_q + port_n;
	wire         long_done = (got_d >= evs_pkg::LONG_BYTES);
	wire [15:0]  fmt_word  = {evs_pkg::THROWAWAY_FMT, 2'h0, vec_q, 2'h0};
	wire [15:0]  push_word = (word_q == 3'h0) ? fmt_word :
	                         (word_q == 3'h1) ? pc_q[15:0] :
	                         (word_q == 3'h2) ? pc_q[31:16] : saved_sr_q; // RULE9
	wire [15:0]  sr_entry  = {2'h0, 1'b1, sr_q[12:11],
	                          (kind_rst ? evs_pkg::IPL_RESET :
	                           (kind_irq ? exc_level_i : sr_q[10:8])),
	                          sr_q[7:0]}; // RULE7
	wire [31:0]  unit_st   = {20'h00000, 1'b0, ~idle, task_sel_q, master_on, vec_q};
	wire [31:0]  rd_mux    =
		(reg_addr_i == evs_pkg::REG_STATUS_REG)  ? {16'h0000, sr_q} :
		(reg_addr_i == evs_pkg::REG_VECTOR_BASE) ? vbr_q :
		(reg_addr_i == evs_pkg::REG_TASK_SP)     ? task_sp_q :
		(reg_addr_i == evs_pkg::REG_IRQ_SP)      ? irq_sp_q :
		(reg_addr_i == evs_pkg::REG_SAVED_SR)    ? {16'h0000, saved_sr_q} :
		(reg_addr_i == evs_pkg::REG_PROG_CNT)    ? pc_q :
		(reg_addr_i == evs_pkg::REG_UNIT_STATE)  ? unit_st : 32'h0000_0000;

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rdata_q <= 32'h0000_0000;
			busy_q  <= 1'b0;
		end
		else
		begin
			rdata_q <= reg_re_i ? rd_mux : 32'h0000_0000;
			// busy from the cycle after a taken request up to the restart cycle
			busy_q  <= take_exc || need_bus;
		end
	end
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			req_q       <= 1'b0;
			mem_addr_o  <= 32'h0000_0000;
			mem_we_o    <= 1'b0;
			mem_iack_o  <= 1'b0;
			mem_wdata_o <= 16'h0000;
		end
		else
		begin
			req_q       <= req_d;
			mem_we_o    <= req_d && (state_q == ST_FRAME);
			mem_iack_o  <= req_d && (state_q == ST_IACK);
			mem_wdata_o <= push_word;
			mem_addr_o  <= (state_q == ST_IACK) ? iack_addr :
			               ((state_q == ST_FRAME) ? push_addr : vec_addr);
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			state_q    <= ST_IDLE;
			sr_q       <= evs_pkg::SR_RESET_VAL;
			saved_sr_q <= 16'h0000;
			vbr_q      <= 32'h0000_0000;
			task_sp_q  <= 32'h0000_0000;
			irq_sp_q   <= 32'h0000_0000;
			pc_q       <= 32'h0000_0000;
			acc_q      <= 32'h0000_0000;
			vec_q      <= 8'h00;
			got_q      <= 3'h0;
			word_q     <= 3'h0;
			task_sel_q <= 1'b0;
			restart_q  <= 1'b0;
		end
		else
		begin
			restart_q <= 1'b0;
			case (state_q)
				ST_IDLE:
				begin
					if (sw_write && reg_addr_i == evs_pkg::REG_STATUS_REG)
						sr_q <= reg_wdata_i[15:0];
					if (sw_write && reg_addr_i == evs_pkg::REG_VECTOR_BASE)
						vbr_q <= reg_wdata_i;
					if (sw_write && reg_addr_i == evs_pkg::REG_TASK_SP)
						task_sp_q <= reg_wdata_i;
					if (sw_write && reg_addr_i == evs_pkg::REG_IRQ_SP)
						irq_sp_q <= reg_wdata_i;
					if (sw_write && reg_addr_i == evs_pkg::REG_PROG_CNT)
						pc_q <= reg_wdata_i;
					if (take_exc)
					begin
						saved_sr_q <= sr_q; // RULE7
						sr_q       <= sr_entry; // RULE7
						got_q      <= 3'h0;
						word_q     <= 3'h0;
						acc_q      <= 32'h0000_0000;
						vec_q      <= int_vec; // RULE8
						if (kind_rst)
						begin
							sr_q[evs_pkg::SR_MASTER] <= 1'b0; // RULE10
							task_sel_q <= 1'b0;
							state_q    <= ST_VEC; // RULE10
						end
						else if (kind_irq)
						begin
							task_sel_q <= 1'b0;
							state_q    <= ST_IACK; // RULE8
						end
						else
						begin
							task_sel_q <= master_on; // RULE1
							state_q    <= ST_VEC;
						end
					end
				end
				ST_IACK:
				begin
					if (acked)
					begin
						vec_q <= mem_rdata_i[7:0]; // RULE8
						sr_q[evs_pkg::SR_MASTER] <= 1'b0; // RULE2
						state_q <= master_on ? ST_FRAME : ST_VEC; // RULE9
					end
				end
				ST_FRAME:
				begin
					if (acked)
					begin
						task_sp_q <= push_addr; // RULE9
						word_q    <= word_q + 3'h1;
						if (word_q == evs_pkg::FRAME_WORDS - 3'h1)
							state_q <= ST_VEC;
					end
				end
				ST_VEC:
				begin
					if (acked)
					begin
						acc_q <= acc_d; // RULE11
						got_q <= got_d;
						if (long_done)
						begin
							pc_q    <= acc_d; // RULE5
							state_q <= ST_DONE;
						end
					end
				end
				ST_DONE:
				begin
					restart_q <= 1'b1; // RULE6
					state_q   <= ST_IDLE;
				end
				default:
				begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	assign reg_rdata_o  = rdata_q;
	assign mem_req_o    = req_q;
	assign busy_o       = busy_q;
	assign task_stack_o = task_sel_q;
	assign restart_o    = restart_q;
	assign fetch_pc_o   = pc_q;
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	a_task_stack_sel: assert property ( // RULE1
		take_exc && !kind_rst && !kind_irq |=> task_sel_q == $past(master_on))
		else $error("task exception took wrong stack");
	a_irq_clears_m: assert property ( // RULE2
		state_q == ST_IACK && acked |=> !master_on && !task_sel_q)
		else $error("interrupt left master bit set");
	a_vec_offset: assert property ( // RULE3
		mem_req_o && state_q == ST_VEC && got_q == 3'h0 |-> mem_addr_o - vbr_q == 32'(vec_q) << 2)
		else $error("vector offset not four times number");
	a_vec_address: assert property ( // RULE4
		state_q == ST_VEC && req_d && got_q == 3'h0 |=>
		mem_addr_o == $past(vbr_q) + ($past(vec_q) * 4))
		else $error("vector address wrong");
	a_pc_restart: assert property ( // RULE5
		state_q == ST_VEC && acked && long_done |=> pc_q == $past(acc_d) ##1 restart_o)
		else $error("pc not loaded before restart");
	a_restart_once: assert property ( // RULE6
		restart_o |-> $past(state_q == ST_DONE) ##1 !restart_o)
		else $error("restart not a single pulse after fetch");
	a_status_entry: assert property ( // RULE7
		take_exc |=> sr_q[evs_pkg::SR_SUPER] && !sr_q[evs_pkg::SR_TRACE_ANY] &&
		!sr_q[evs_pkg::SR_TRACE_FLOW] && saved_sr_q == $past(sr_q))
		else $error("status not updated on entry");
	a_irq_iack: assert property ( // RULE8
		take_exc && kind_irq |=> ##1 mem_req_o && mem_iack_o && !mem_we_o)
		else $error("interrupt did not run acknowledge cycle");
	a_frame_words: assert property ( // RULE9
		state_q == ST_IACK && acked && master_on |=> state_q == ST_FRAME && word_q == 3'h0)
		else $error("throwaway frame not started");
	a_reset_nostack: assert property ( // RULE10
		take_exc && kind_rst |=> state_q == ST_VEC && !master_on && vec_q == 8'h00)
		else $error("reset exception stacked or kept master bit");
	a_long_read: assert property ( // RULE11
		state_q == ST_VEC && mem_req_o |-> !mem_we_o && !mem_iack_o)
		else $error("vector read not a plain read");
endmodule

// ### test/evs_mem_model.sv
/*
 * memory model on the far side of the vector fetch port: answers reads and
 * acknowledge cycles, logs every finished cycle for the bench.
 * assumes one request at a time, held until ack.
 */
`timescale 1ns/1ps
module evs_mem_model
(
	input  wire logic        sys_clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        req_i,
	input  wire logic        we_i,
	input  wire logic        iack_i,
	input  wire logic [31:0] addr_i,
	input  wire logic [15:0] wdata_i,
	input  wire logic [1:0]  port_i,
	input  wire logic [3:0]  wait_i,
	input  wire logic [7:0]  ivec_i,
	output logic             ack_o,
	output logic      [1:0]  port_o,
	output logic      [31:0] rdata_o
);
	logic [3:0]  cnt_q;
	logic [31:0] lw;
	logic [31:0] chunk;
	logic [31:0] log_addr [0:63];
	logic [15:0] log_data [0:63];
	int          log_n;
	assign port_o = port_i;
	assign lw = {addr_i[31:2], 2'h0} ^ 32'h5A5A_A5A5;
	// first chunk carries the most significant bytes on the upper lanes
	assign chunk = iack_i ? {24'h0, ivec_i} : lw << {addr_i[1:0], 3'h0};
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			ack_o <= 1'b0;
			cnt_q <= 4'h0;
			rdata_o <= 32'h0;
			log_n <= 0;
		end
		else if (req_i && !ack_o && cnt_q == wait_i)
		begin
			ack_o <= 1'b1;
			cnt_q <= 4'h0;
			rdata_o <= chunk;
		end
		else
		begin
			ack_o <= 1'b0;
			rdata_o <= ~rdata_o;
			if (req_i && !ack_o)
				cnt_q <= cnt_q + 4'h1;
			if (req_i && ack_o)
			begin
				log_addr[log_n] <= addr_i;
				log_data[log_n] <= we_i ? wdata_i : 16'h0;
				log_n <= log_n + 1;
			end
		end
	end
endmodule

// ### test/evs_top_tb_top.sv
/*
 * bench for the exception unit: register tasks and exception sequences.
 * assumes the memory model answers every bus cycle of the device.
 */
`timescale 1ns/1ps
module evs_top_tb_top;
	logic        clk = 1'b0;
	logic        rst_n;
	logic [7:0]  addr;
	logic [31:0] wdata;
	logic        we;
	logic        re;
	logic [31:0] rdata;
	logic        exc_req;
	logic [1:0]  kind;
	logic [7:0]  vec;
	logic [7:0]  cop;
	logic [2:0]  lvl;
	logic        mreq;
	logic        mwe;
	logic        miack;
	logic [31:0] maddr;
	logic [15:0] mwdata;
	logic        mack;
	logic [1:0]  mport;
	logic [31:0] mrdata;
	logic        busy;
	logic        tstack;
	logic        restart;
	logic [31:0] fpc;
	logic [1:0]  port;
	logic [3:0]  waitc;
	logic [7:0]  ivec;
	logic        ts;
	logic [31:0] pc0;
	logic [15:0] fr [0:3];
	int          n0;
	int          n_errors = 0;
	int          comparisons = 0;
	always #5 clk = ~clk;
	evs_top u_evs_top (.sys_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata), .exc_req_i(exc_req),
		.exc_kind_i(kind), .exc_vec_i(vec), .cop_vec_i(cop), .exc_level_i(lvl),
		.mem_req_o(mreq), .mem_we_o(mwe), .mem_iack_o(miack), .mem_addr_o(maddr),
		.mem_wdata_o(mwdata), .mem_ack_i(mack), .mem_port_i(mport), .mem_rdata_i(mrdata),
		.busy_o(busy), .task_stack_o(tstack), .restart_o(restart), .fetch_pc_o(fpc));
	evs_mem_model u_evs_mem_model (.sys_clk_i(clk), .rst_n_i(rst_n), .req_i(mreq), .we_i(mwe),
		.iack_i(miack), .addr_i(maddr), .wdata_i(mwdata), .port_i(port), .wait_i(waitc),
		.ivec_i(ivec), .ack_o(mack), .port_o(mport), .rdata_o(mrdata));
	function automatic logic [31:0] mf(input logic [31:0] a);
		return a ^ 32'h5A5A_A5A5;
	endfunction
	task automatic stop_test();
		$display("errors=%0d comparisons=%0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp)
		begin
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
			n_errors++;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		we <= 1'b1;
		@(posedge clk);
		we <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
		@(posedge clk);
		addr <= a;
		re <= 1'b1;
		@(posedge clk);
		re <= 1'b0;
		#1 chk(nm, exp, rdata);
	endtask
	task automatic exc(input logic [1:0] k, input logic [7:0] v, input logic [7:0] c,
		input logic [2:0] l);
		int i;
		n0 = u_evs_mem_model.log_n;
		@(posedge clk);
		kind <= k;
		vec <= v;
		cop <= c;
		lvl <= l;
		exc_req <= 1'b1;
		@(posedge clk);
		exc_req <= 1'b0;
		#1 chk("busy", 32'h1, {31'h0, busy});
		ts = tstack;
		i = 0;
		while (restart !== 1'b1 && i < 300)
		begin
			@(posedge clk);
			#1 i++;
		end
		if (i >= 300)
		begin
			n_errors++;
			stop_test();
		end
	endtask
	initial
	begin
		{rst_n, addr, wdata, we, re, exc_req, kind, vec, cop, lvl, ivec} <= '0;
		port <= evs_pkg::PORT_32;
		waitc <= 4'h0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		rd(evs_pkg::REG_STATUS_REG, 32'h0000_2700, "status_rst");
		wr(evs_pkg::REG_VECTOR_BASE, 32'h0000_1000);
		wr(evs_pkg::REG_TASK_SP, 32'h0000_2000);
		wr(evs_pkg::REG_IRQ_SP, 32'h0000_3000);
		wr(evs_pkg::REG_STATUS_REG, 32'h0000_F000);
		// internal exception, master bit set, 32-bit port
		exc(evs_pkg::EVS_KIND_INTERNAL, 8'h05, 8'hEE, 3'h0);
		chk("tstack", 32'h1, {31'h0, ts});
		chk("vaddr", 32'h0000_1014, u_evs_mem_model.log_addr[n0]);
		chk("pc", mf(32'h0000_1014), fpc);
		rd(evs_pkg::REG_STATUS_REG, 32'h0000_3000, "status");
		rd(evs_pkg::REG_SAVED_SR, 32'h0000_F000, "saved");
		// state word: task stack in bit 9, master bit in bit 8, vector number below
		rd(evs_pkg::REG_UNIT_STATE, 32'h0000_0305, "unit_state");
		// interrupt with master bit set, 16-bit port, slow answers
		pc0 = mf(32'h0000_1014);
		fr = '{16'h1100, pc0[15:0], pc0[31:16], 16'h3000};
		port <= evs_pkg::PORT_16;
		waitc <= 4'h1;
		ivec <= 8'h40;
		exc(evs_pkg::EVS_KIND_IRQ, 8'hEE, 8'hEE, 3'h3);
		chk("tstack", 32'h0, {31'h0, ts});
		chk("iack", 32'hFFFF_FFF7, u_evs_mem_model.log_addr[n0]);
		for (int i = 0; i < 4; i++)
		begin
			chk("fr_addr", 32'h0000_1FFE - 2 * i, u_evs_mem_model.log_addr[n0 + 1 + i]);
			chk("fr_data", {16'h0, fr[i]}, {16'h0, u_evs_mem_model.log_data[n0 + 1 + i]});
		end
		chk("vaddr_hi", 32'h0000_1100, u_evs_mem_model.log_addr[n0 + 5]);
		chk("vaddr_lo", 32'h0000_1102, u_evs_mem_model.log_addr[n0 + 6]);
		chk("pc", mf(32'h0000_1100), fpc);
		rd(evs_pkg::REG_STATUS_REG, 32'h0000_2300, "status");
		// coprocessor exception, 8-bit port
		port <= evs_pkg::PORT_8;
		waitc <= 4'h2;
		exc(evs_pkg::EVS_KIND_COPROC, 8'hEE, 8'h21, 3'h0);
		chk("tstack", 32'h0, {31'h0, ts});
		for (int i = 0; i < 4; i++)
			chk("vaddr_b", 32'h0000_1084 + i, u_evs_mem_model.log_addr[n0 + i]);
		chk("pc", mf(32'h0000_1084), fpc);
		// interrupt with master bit clear: acknowledge then vector, no frame
		port <= evs_pkg::PORT_32;
		ivec <= 8'h10;
		exc(evs_pkg::EVS_KIND_IRQ, 8'hEE, 8'hEE, 3'h5);
		chk("tstack", 32'h0, {31'h0, ts});
		chk("cycles", 32'h2, u_evs_mem_model.log_n - n0);
		chk("iack", 32'hFFFF_FFFB, u_evs_mem_model.log_addr[n0]);
		chk("vaddr", 32'h0000_1040, u_evs_mem_model.log_addr[n0 + 1]);
		chk("pc", mf(32'h0000_1040), fpc);
		rd(evs_pkg::REG_TASK_SP, 32'h0000_1FF8, "task_sp");
		rd(evs_pkg::REG_STATUS_REG, 32'h0000_2500, "status");
		// reset exception with master bit set
		wr(evs_pkg::REG_STATUS_REG, 32'h0000_F000);
		port <= evs_pkg::PORT_32;
		exc(evs_pkg::EVS_KIND_RESET, 8'hEE, 8'hEE, 3'h2);
		chk("tstack", 32'h0, {31'h0, ts});
		chk("cycles", 32'h1, u_evs_mem_model.log_n - n0);
		chk("vaddr", 32'h0000_1000, u_evs_mem_model.log_addr[n0]);
		chk("pc", mf(32'h0000_1000), fpc);
		rd(evs_pkg::REG_STATUS_REG, 32'h0000_2700, "status");
		stop_test();
	end
endmodule
